// ---- design/osr_pkg.sv ----
/*
 Shared constants for the one-time-programmable security region access over SPI:
 opcodes, region layout, status bit positions and timing counts.
 Assumes a 125 MHz system clock on both ends of the link.
*/
package osr_pkg;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_PROG = 8'h9B;
   localparam logic [7:0] OP_READ = 8'h77;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam int REGION_BYTES = 128;
   localparam int USER_BYTES = 64;
   localparam int STAGE_BYTES = 256;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BYTES = 2;
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   // Value is arbitrary, stands in for the per-part factory content
   localparam logic [7:0] FACTORY_SEED = 8'h5A;
   localparam int CLK_PERIOD_NS = 8;
   // otp_program_time: longest time, rounded down to whole cycles
   localparam int OTP_PROG_TIME_NS = 100000;
   localparam int OTP_PROG_CYCLES = OTP_PROG_TIME_NS / CLK_PERIOD_NS;
   // Host link clock: 160 ns period, half of it in system cycles
   localparam int SCK_PERIOD_NS = 160;
   localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int RX_FIFO_DEPTH = 2;

   function automatic logic [7:0] factory_byte(input int idx, input logic [7:0] seed);
      return 8'(idx) ^ seed;
   endfunction
endpackage

// ---- design/osr_spi_if.sv ----
/*
 SPI link between the host controller end and the security region device end.
 Assumes the bench resolves the serial out wire from the device enable.
*/
`timescale 1ns/1ps
interface osr_spi_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe_n;

   modport dev (input cs_n, input sck, input mosi, output miso, output miso_oe_n);
   modport host (output cs_n, output sck, output mosi, input miso);
endinterface

// ---- design/osr_dev.sv ----
/*
 Device end: security region store, command decoder, program sequencer and status.
 Assumes the link pins are asynchronous to clk_i and much slower than it.
*/
`timescale 1ns/1ps
module osr_dev #(
   parameter int unsigned PROG_CYCLES = osr_pkg::OTP_PROG_CYCLES,
   parameter logic [7:0] FACTORY_SEED = osr_pkg::FACTORY_SEED
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   osr_spi_if.dev spi,
   output logic busy_o,
   output logic write_latch_flag_o,
   output logic programmed_o
);
   import osr_pkg::*;

   typedef enum logic [2:0] {OSR_CMD, OSR_ADDR, OSR_DUMMY, OSR_PDATA, OSR_RDATA, OSR_STAT, OSR_SKIP} osr_dstate_t;

   osr_dstate_t state;
   logic cs_q1, cs_q2, cs_d, sck_q1, sck_q2, sck_d, mosi_q1, mosi_q2;
   logic [2:0] bit_cnt;
   logic [7:0] in_sh;
   logic [7:0] opcode;
   logic [1:0] phase_cnt;
   logic [5:0] prog_start;
   logic [5:0] prog_cnt;
   logic prog_any;
   logic [63:0] prog_mask;
   logic [6:0] rd_start;
   logic [6:0] rd_addr;
   logic [7:0] out_sh;
   logic [2:0] out_cnt;
   logic miso, miso_oe_n;
   logic busy, write_latch_flag, programmed;
   logic [31:0] timer;
   logic [7:0] otp [REGION_BYTES];
   logic [7:0] stage_buf [STAGE_BYTES];

   // Two flops on every pin before any logic looks at it
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         {cs_q1, cs_q2, cs_d} <= 3'h7;
         {sck_q1, sck_q2, sck_d} <= 3'h0;
         {mosi_q1, mosi_q2} <= 2'h0;
      end
      else
      begin
         {cs_q1, cs_q2, cs_d} <= {spi.cs_n, cs_q1, cs_q2};
         {sck_q1, sck_q2, sck_d} <= {spi.sck, sck_q1, sck_q2};
         {mosi_q1, mosi_q2} <= {spi.mosi, mosi_q1};
      end
   end

   // Edge and frame decode
   wire active = ~cs_q2;
   wire sck_rise = sck_q2 & ~sck_d;
   wire sck_fall = ~sck_q2 & sck_d;
   wire cs_rise = cs_q2 & ~cs_d;
   wire byte_done = active & sck_rise & (bit_cnt == 3'h7);
   wire [7:0] in_byte = {in_sh[6:0], mosi_q2};
   wire [5:0] prog_loc = prog_start + prog_cnt;
   wire [7:0] status_byte = {6'h00, write_latch_flag, busy};
   wire [7:0] next_out = (state == OSR_RDATA) ? otp[rd_addr] : status_byte;
   wire commit = busy & (timer == 32'h0);
   // Aligned frame, full address, at least one data byte, never programmed
   wire prog_ok = (state == OSR_PDATA) & prog_any & (bit_cnt == 3'h0) & ~programmed;
   wire wren_ok = (opcode == OP_WREN) & (state == OSR_SKIP) & (bit_cnt == 3'h0) & ~busy;

   // Input shifter, sampled on rising link clock
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         bit_cnt <= 3'h0;
         in_sh <= 8'h00;
      end
      else if (!active)
         bit_cnt <= 3'h0;
      else if (sck_rise)
      begin
         bit_cnt <= bit_cnt + 3'h1;
         in_sh <= in_byte;
      end
   end

   // Command sequencer; chip select high returns to opcode phase
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state <= OSR_CMD;
         opcode <= 8'h00;
         phase_cnt <= 2'h0;
         prog_start <= 6'h00;
         prog_cnt <= 6'h00;
         prog_any <= 1'b0;
         prog_mask <= 64'h0;
         rd_start <= 7'h00;
      end
      else if (!active)
         state <= OSR_CMD;
      else if (byte_done)
      begin
         case (state)
            OSR_CMD:
            begin
               opcode <= in_byte;
               phase_cnt <= 2'h0;
               if (in_byte == OP_STATUS)
                  state <= OSR_STAT;
               else if (busy)
                  state <= OSR_SKIP;
               else if ((in_byte == OP_PROG && write_latch_flag) || in_byte == OP_READ)
                  state <= OSR_ADDR;
               else
                  state <= OSR_SKIP;
            end
            OSR_ADDR:
            begin
               phase_cnt <= phase_cnt + 2'h1;
               if (phase_cnt == 2'(ADDR_BYTES - 1))
               begin
                  phase_cnt <= 2'h0;
                  if (opcode == OP_PROG)
                  begin
                     state <= OSR_PDATA;
                     prog_start <= in_byte[5:0];
                     prog_cnt <= 6'h00;
                     prog_any <= 1'b0;
                     prog_mask <= 64'h0;
                  end
                  else
                  begin
                     state <= OSR_DUMMY;
                     rd_start <= in_byte[6:0];
                  end
               end
            end
            OSR_DUMMY:
            begin
               phase_cnt <= phase_cnt + 2'h1;
               if (phase_cnt == 2'(DUMMY_BYTES - 1))
                  state <= OSR_RDATA;
            end
            OSR_PDATA:
            begin
               // Counter wraps, so later bytes overwrite and the last 64 stay
               prog_cnt <= prog_cnt + 6'h01;
               prog_any <= 1'b1;
               prog_mask[prog_loc] <= 1'b1;
            end
            default:
            begin
            end
         endcase
      end
   end

   // Staging writes land in the shared page buffer, old contents lost
   always_ff @(posedge clk_i)
   begin
      if (byte_done && state == OSR_PDATA)
         stage_buf[{2'h0, prog_loc}] <= in_byte;
   end

   // Output shifter, changes on falling link clock
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         out_sh <= 8'h00;
         out_cnt <= 3'h0;
         rd_addr <= 7'h00;
         miso <= 1'b0;
         miso_oe_n <= 1'b1;
      end
      else if (!active)
      begin
         out_cnt <= 3'h0;
         miso_oe_n <= 1'b1;
      end
      else if (byte_done && state == OSR_CMD)
      begin
         out_sh <= status_byte;
         out_cnt <= 3'h0;
      end
      else if (byte_done && state == OSR_DUMMY && phase_cnt == 2'(DUMMY_BYTES - 1))
      begin
         out_sh <= otp[rd_start];
         rd_addr <= rd_start + 7'h01;
         out_cnt <= 3'h0;
      end
      else if (sck_fall && (state == OSR_RDATA || state == OSR_STAT))
      begin
         miso <= out_sh[7];
         miso_oe_n <= 1'b0;
         out_cnt <= out_cnt + 3'h1;
         out_sh <= {out_sh[6:0], 1'b0};
         if (out_cnt == 3'h7)
         begin
            // Reloads every byte, so status is fresh each time
            out_sh <= next_out;
            if (state == OSR_RDATA)
               rd_addr <= rd_addr + 7'h01;
         end
      end
   end

   // Write latch, busy timer and the once-only lock
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         write_latch_flag <= 1'b0;
         busy <= 1'b0;
         programmed <= 1'b0;
         timer <= 32'h0;
      end
      else
      begin
         if (busy)
         begin
            timer <= timer - 32'h1;
            if (commit)
               busy <= 1'b0;
         end
         if (cs_rise)
         begin
            if (wren_ok)
               write_latch_flag <= 1'b1;
            else if (opcode == OP_PROG && (state == OSR_ADDR || state == OSR_PDATA))
            begin
               write_latch_flag <= 1'b0;
               if (prog_ok)
               begin
                  busy <= 1'b1;
                  timer <= 32'(PROG_CYCLES - 1);
                  // Locked at start, so reuse is blocked from the program start until sys_rst_i clears the lock
                  programmed <= 1'b1;
               end
            end
         end
      end
   end

   // Region store; flash bits only go from 1 to 0
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < REGION_BYTES; i++)
            otp[i] <= (i < USER_BYTES) ? ERASED_BYTE : factory_byte(i, FACTORY_SEED);
      end
      else if (commit)
      begin
         for (int i = 0; i < USER_BYTES; i++)
            if (prog_mask[i])
               otp[i] <= otp[i] & stage_buf[i];
      end
   end

   assign spi.miso = miso;
   assign spi.miso_oe_n = miso_oe_n;
   assign busy_o = busy;
   assign write_latch_flag_o = write_latch_flag;
   assign programmed_o = programmed;
endmodule // osr_dev

// ---- design/osr_host.sv ----
/*
 Host end: runs one SPI frame per command, makes the link clock by division,
 and hands read bytes to the user through a small buffer.
 Assumes the bench resolves serial out onto spi.miso.
*/
`timescale 1ns/1ps
module osr_host #(
   parameter int HALF_CYCLES = osr_pkg::SCK_HALF_CYCLES,
   parameter int DEPTH = osr_pkg::RX_FIFO_DEPTH,
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] cmd_op_i,
   input wire logic [23:0] cmd_addr_i,
   input wire logic [15:0] cmd_len_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [7:0] tx_data_i,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [WIDTH-1:0] rx_data_o,
   output logic busy_o,
   osr_spi_if.host spi
);
   import osr_pkg::*;

   typedef enum logic [2:0] {OSH_IDLE, OSH_LOAD, OSH_LOW, OSH_HIGH, OSH_END, OSH_GAP} osr_hstate_t;

   osr_hstate_t state;
   logic [7:0] op;
   logic [23:0] addr;
   logic [15:0] total, byte_idx, hdr;
   logic [7:0] sh, rx_sh;
   logic [2:0] bit_cnt;
   logic [15:0] div;
   logic cs_n, sck, mosi, miso_q1, miso_q2;
   logic [WIDTH-1:0] fifo [DEPTH];
   logic [$clog2(DEPTH)-1:0] wr_ptr, rd_ptr;
   logic [$clog2(DEPTH+1)-1:0] count;

   // Byte plan of the current frame
   wire is_wr = (op == OP_PROG);
   wire in_data = (byte_idx >= hdr);
   wire half_done = (div == 16'(HALF_CYCLES - 1));
   wire fifo_space = (count < ($clog2(DEPTH+1))'(DEPTH));
   wire load_stall = in_data & (is_wr ? ~tx_valid_i : ~fifo_space);
   wire [7:0] hdr_byte = (byte_idx == 16'h0) ? op : (byte_idx == 16'h1) ? addr[23:16] :
                         (byte_idx == 16'h2) ? addr[15:8] : (byte_idx == 16'h3) ? addr[7:0] : DUMMY_BYTE;
   wire [7:0] next_sh = in_data ? (is_wr ? tx_data_i : DUMMY_BYTE) : hdr_byte;
   wire [7:0] rx_byte = {rx_sh[6:0], miso_q2};
   wire push = (state == OSH_HIGH) & half_done & (bit_cnt == 3'h7) & in_data & ~is_wr;
   wire pop = rx_valid_o & rx_ready_i;

   assign cmd_ready_o = (state == OSH_IDLE);
   assign tx_ready_o = (state == OSH_LOAD) & (byte_idx != total) & in_data & is_wr;
   assign busy_o = (state != OSH_IDLE);
   assign rx_valid_o = (count != '0);
   assign rx_data_o = fifo[rd_ptr];
   assign spi.cs_n = cs_n;
   assign spi.sck = sck;
   assign spi.mosi = mosi;

   // Serial in crosses from the device side
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         {miso_q1, miso_q2} <= 2'h0;
      else
         {miso_q1, miso_q2} <= {spi.miso, miso_q1};
   end

   // Frame engine, mode 0: clock idles low, data set while low
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state <= OSH_IDLE;
         {op, addr, total, byte_idx, hdr} <= '0;
         {sh, rx_sh, bit_cnt, div} <= '0;
         cs_n <= 1'b1;
         sck <= 1'b0;
         mosi <= 1'b0;
      end
      else
      begin
         div <= div + 16'h1;
         case (state)
            OSH_IDLE:
               if (cmd_valid_i)
               begin
                  op <= cmd_op_i;
                  addr <= cmd_addr_i;
                  hdr <= (cmd_op_i == OP_PROG) ? 16'(1 + ADDR_BYTES) :
                         (cmd_op_i == OP_READ) ? 16'(1 + ADDR_BYTES + DUMMY_BYTES) : 16'h1;
                  total <= cmd_len_i + ((cmd_op_i == OP_PROG) ? 16'(1 + ADDR_BYTES) :
                           (cmd_op_i == OP_READ) ? 16'(1 + ADDR_BYTES + DUMMY_BYTES) : 16'h1);
                  byte_idx <= 16'h0;
                  cs_n <= 1'b0;
                  state <= OSH_LOAD;
               end
            OSH_LOAD:
            begin
               div <= 16'h0;
               if (byte_idx == total)
                  state <= OSH_END;
               else if (!load_stall)
               begin
                  // Stalls the link clock when the receiver is full
                  sh <= next_sh;
                  mosi <= next_sh[7];
                  bit_cnt <= 3'h0;
                  state <= OSH_LOW;
               end
            end
            OSH_LOW:
               if (half_done)
               begin
                  sck <= 1'b1;
                  div <= 16'h0;
                  state <= OSH_HIGH;
               end
            OSH_HIGH:
               if (half_done)
               begin
                  // Sampling late in the high half leaves room for device delay
                  sck <= 1'b0;
                  div <= 16'h0;
                  rx_sh <= rx_byte;
                  sh <= {sh[6:0], 1'b0};
                  mosi <= sh[6];
                  bit_cnt <= bit_cnt + 3'h1;
                  state <= OSH_LOW;
                  if (bit_cnt == 3'h7)
                  begin
                     byte_idx <= byte_idx + 16'h1;
                     state <= OSH_LOAD;
                  end
               end
            OSH_END:
               if (half_done)
               begin
                  cs_n <= 1'b1;
                  div <= 16'h0;
                  state <= OSH_GAP;
               end
            default:
               if (half_done)
                  state <= OSH_IDLE;
         endcase
      end
   end

   // Receive buffer; space is checked before each read byte starts
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         fifo[wr_ptr] <= rx_byte;
   end
endmodule // osr_host

// ---- test/osr_link_assertions.sv ----
/*
 Checker for the SPI link joining the host and device ends of the security region block.
 Assumes it sits beside the interface and sees the device status flags as plain inputs.
*/
`timescale 1ns/1ps
module osr_link_chk #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire logic busy_o,
   input wire logic write_latch_flag_o
);
   logic [15:0] busy_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Busy length counter, too long a window for a repetition
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         busy_cnt <= 16'h0000;
      else
         busy_cnt <= busy_o ? busy_cnt + 16'h0001 : 16'h0000;
   end
   // Deselect, and program entry with latch drop
   sequence frame_end;
      $rose(cs_n) ##1 cs_n;
   endsequence
   sequence prog_start;
      $rose(busy_o) ##0 $fell(write_latch_flag_o);
   endsequence
   chk_oe_release: assert property (frame_end |-> ##[0:5] miso_oe_n)
      else $error("serial out still driven after deselect");
   chk_oe_idle: assert property (cs_n && $past(cs_n, 8) |-> miso_oe_n)
      else $error("serial out driven while deselected");
   chk_oe_start: assert property ($fell(miso_oe_n) |-> !cs_n && !sck)
      else $error("serial out enabled outside a low clock phase");
   chk_sck_idle: assert property (cs_n |-> !sck)
      else $error("link clock high while deselected");
   chk_mosi_hold: assert property (sck |-> $stable(mosi))
      else $error("serial in changed while clock high");
   chk_miso_hold: assert property (sck && !miso_oe_n |-> $stable(miso))
      else $error("serial out changed while clock high");
   chk_prog_cause: assert property (prog_start |-> cs_n && $past(cs_n, 2))
      else $error("programming began without a deselect");
   chk_busy_latch: assert property ($rose(busy_o) |-> $fell(write_latch_flag_o))
      else $error("programming began without write latch dropping");
   chk_busy_nolatch: assert property (busy_o |-> !write_latch_flag_o)
      else $error("write latch set while busy");
   chk_prog_time: assert property ($fell(busy_o) |->
      busy_cnt >= 16'(PROG_CYCLES - 1) && busy_cnt <= 16'(PROG_CYCLES + 1))
      else $error("program time differs from the set count");
   chk_latch_set: assert property ($rose(write_latch_flag_o) |-> cs_n && !busy_o)
      else $error("write latch set mid-frame or while busy");
endmodule // osr_link_chk

// ---- test/otp_security_region_access_tb_top.sv ----
/*
 Testbench joining host and device ends, plus a second device driven by hand-made frames.
 Assumes the host and device ends and the shared package as delivered.
*/
`timescale 1ns/1ps
module otp_security_region_access_tb_top;
   import osr_pkg::*;
   localparam int PC = 2000;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i, cmd_ready_o, tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i;
   logic hbusy, dbusy, write_latch_flag, locked, busy2, write_latch_flag2, locked2;
   logic [7:0] cmd_op_i, tx_data_i, rx_data_o;
   logic [23:0] cmd_addr_i;
   logic [15:0] cmd_len_i;
   logic [7:0] expm [128];
   logic [7:0] tx_q [$];
   logic [7:0] rx_q [$];
   int err_total = 0;
   int n_compared = 0;
   osr_spi_if spi();
   osr_spi_if spi2();
   // Ends under test, and a second device for broken frames
   osr_host osr_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
      .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .busy_o(hbusy), .spi(spi.host));
   osr_dev #(.PROG_CYCLES(PC)) osr_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi(spi.dev),
      .busy_o(dbusy), .write_latch_flag_o(write_latch_flag), .programmed_o(locked));
   osr_dev #(.PROG_CYCLES(PC)) osr_dev_fault_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi(spi2.dev),
      .busy_o(busy2), .write_latch_flag_o(write_latch_flag2), .programmed_o(locked2));
   osr_link_chk #(.PROG_CYCLES(PC)) osr_link_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .cs_n(spi.cs_n), .sck(spi.sck), .mosi(spi.mosi), .miso(spi.miso), .miso_oe_n(spi.miso_oe_n),
      .busy_o(dbusy), .write_latch_flag_o(write_latch_flag));
   // Clock, and a watchdog well past the expected run
   initial forever #4 clk_i = ~clk_i;
   initial
   begin
      #720000;
      err_total++;
      finish_test();
   end
   // Program data feeder and read data collector
   always @(posedge clk_i)
   begin
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
         void'(tx_q.pop_front());
      #1;
      tx_valid_i = (tx_q.size() != 0);
      tx_data_i = (tx_q.size() != 0) ? tx_q[0] : 8'h00;
   end
   always @(posedge clk_i)
      if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
         rx_q.push_back(rx_data_o);

   task automatic finish_test();
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic init_exp();
      for (int i = 0; i < 128; i++)
         expm[i] = (i < 64) ? ERASED_BYTE : 8'(i) ^ FACTORY_SEED;
   endtask
   // One command frame; waits for the host to go idle, bounded
   task automatic run(logic [7:0] op, logic [23:0] a, int len);
      int k;
      k = 0;
      while (cmd_ready_o !== 1'b1 && k < 50000)
      begin
         tick(1);
         k++;
      end
      cmd_op_i = op;
      cmd_addr_i = a;
      cmd_len_i = 16'(len);
      cmd_valid_i = 1'b1;
      tick(1);
      cmd_valid_i = 1'b0;
      tick(1);
      while (hbusy !== 1'b0 && k < 50000)
      begin
         tick(1);
         k++;
      end
      if (k >= 50000)
      begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic status(int n);
      rx_q.delete();
      run(OP_STATUS, 24'h000000, n);
      tick(4);
   endtask
   // Poll until ready; busy costs a few frames at most
   task automatic poll();
      int k;
      k = 0;
      status(1);
      while (rx_q[0][ST_BUSY_BIT] !== 1'b0 && k < 30)
      begin
         status(1);
         k++;
      end
      if (k >= 30)
      begin
         err_total++;
         finish_test();
      end
      check(rx_q[0], 8'h00);
   endtask
   // Read with an optional long receiver stall to fill the buffer
   task automatic rd(logic [23:0] a, int n, bit stall);
      rx_q.delete();
      rx_ready_i = !stall;
      if (stall)
         fork
            begin
               tick(3000);
               check(8'(rx_valid_o), 8'h01);
               check(8'(rx_q.size()), 8'h00);
               rx_ready_i = 1'b1;
            end
         join_none
      run(OP_READ, a, n);
      tick(4);
      for (int i = 0; i < n; i++)
         check(rx_q[i], expm[(int'(a[6:0]) + i) % 128]);
   endtask
   task automatic prog(logic [23:0] a, int n, logic [7:0] salt, bit upd);
      for (int i = 0; i < n; i++)
      begin
         tx_q.push_back(8'(i) ^ salt);
         if (upd)
            expm[(int'(a[5:0]) + i) % 64] = 8'(i) ^ salt;
      end
      run(OP_PROG, a, n);
   endtask
   // Hand-made frame on the second link, n bits MSB first
   task automatic frame2(logic [63:0] v, int n);
      spi2.cs_n = 1'b0;
      tick(4);
      for (int i = n - 1; i >= 0; i--)
      begin
         spi2.mosi = v[i];
         tick(SCK_HALF_CYCLES);
         spi2.sck = 1'b1;
         tick(SCK_HALF_CYCLES);
         spi2.sck = 1'b0;
      end
      tick(SCK_HALF_CYCLES);
      spi2.cs_n = 1'b1;
      tick(10);
   endtask

   // Main sequence
   initial
   begin
      cmd_valid_i = 1'b0;
      cmd_op_i = 8'h00;
      cmd_addr_i = 24'h000000;
      cmd_len_i = 16'h0000;
      tx_valid_i = 1'b0;
      tx_data_i = 8'h00;
      rx_ready_i = 1'b1;
      spi2.cs_n = 1'b1;
      spi2.sck = 1'b0;
      spi2.mosi = 1'b0;
      init_exp();
      tick(4);
      sys_rst_i = 1'b0;
      tick(2);
      rd(24'hABCD7E, 4, 1'b0);
      prog(24'h000000, 1, 8'h11, 1'b0);
      check(8'({dbusy, locked}), 8'h00);
      run(OP_WREN, 24'h000000, 0);
      check(8'(write_latch_flag), 8'h01);
      status(2);
      check(rx_q[0], 8'h02);
      check(rx_q[1], 8'h02);
      prog(24'hFFFF3E, 3, 8'hA5, 1'b1);
      status(1);
      check(rx_q[0], 8'h01);
      poll();
      check(8'(locked), 8'h01);
      rd(24'h000000, 128, 1'b1);
      run(OP_WREN, 24'h000000, 0);
      prog(24'h000000, 1, 8'h00, 1'b0);
      check(8'({dbusy, write_latch_flag}), 8'h00);
      rd(24'h00003E, 3, 1'b0);
      sys_rst_i = 1'b1;
      tick(2);
      sys_rst_i = 1'b0;
      init_exp();
      tick(2);
      run(OP_WREN, 24'h000000, 0);
      prog(24'h000005, 66, 8'h3C, 1'b1);
      poll();
      rd(24'h000000, 64, 1'b0);
      frame2(64'h06, 8);
      check(8'(write_latch_flag2), 8'h01);
      frame2(64'h9B000000A, 36);
      check(8'({busy2, write_latch_flag2, locked2}), 8'h00);
      frame2(64'h06, 8);
      frame2(64'h9B0000, 24);
      check(8'({busy2, write_latch_flag2, locked2}), 8'h00);
      frame2(64'h06, 8);
      frame2(64'h9B000000, 32);
      check(8'({busy2, write_latch_flag2, locked2}), 8'h00);
      frame2(64'h3B80000000000, 51);
      check(8'(spi2.miso_oe_n), 8'h01);
      finish_test();
   end
endmodule // otp_security_region_access_tb_top
